/* inc/csp_consts.svh */
// Purpose: Constants of the standard PWM unit: field positions, reset values, counts.
// Assumes: One system clock; the period timer advances once per four prescaled clocks.
// Notes:   Included by its bare name; definitions only.
`ifndef CSP_CONSTS_SVH
`define CSP_CONSTS_SVH

// ============================================================
// Unit control byte
`define CSP_CTRL_EN_BIT        7
`define CSP_CTRL_OUT_BIT       5
`define CSP_CTRL_ALIGN_BIT     4
`define CSP_CTRL_MODE_MSB      3
`define CSP_CTRL_MODE_LSB      0
`define CSP_CTRL_WR_MASK       8'h9f
`define CSP_CTRL_RST           8'h00
`define CSP_MODE_PWM_TOP       2'h3

// ============================================================
// Timer control byte
`define CSP_TCTRL_RUN_BIT      7
`define CSP_TCTRL_PS_MSB       6
`define CSP_TCTRL_PS_LSB       4
`define CSP_TCTRL_POST_MSB     3
`define CSP_TCTRL_POST_LSB     0
`define CSP_TCTRL_RST          8'h00

// ============================================================
// Other reset values
`define CSP_DUTY_RST           8'h00
`define CSP_PERIOD_RST         8'hff
`define CSP_COUNT_RST          8'h00
`define CSP_PIN_DIR_RST        1'b1
`define CSP_OPEN_DRAIN_RST     1'b0

// ============================================================
// Timing: system clocks per period timer step at 1:1 prescale
`define CSP_CLK_PERIOD_NS      10
`define CSP_CLKS_PER_STEP      4
`define CSP_PHASE_LAST         2'h3

`endif

/* inc/csp_pkg.sv */
// Purpose: Types shared by the standard PWM unit.
// Assumes: Nothing beyond the constants header.
// Notes:   Operating mode is decoded once from the control byte.
package csp_pkg;

  // ============================================================
  // Operating modes
  typedef enum logic [1:0] {
    CSP_MODE_OFF,
    CSP_MODE_PWM,
    CSP_MODE_OTHER
  } csp_mode_type;

  // ============================================================
  // Duty alignment
  typedef enum logic {
    CSP_ALIGN_RIGHT,
    CSP_ALIGN_LEFT
  } csp_align_type;

endpackage : csp_pkg

/* rtl/csp_timebase.sv */
// Purpose: Prescaler, 8-bit period counter and postscaler forming the 10-bit time base.
// Assumes: Period counter steps once per four prescaled system clocks.
// Notes:   Low two time base bits count prescaled clocks; at 1:1 they are the clock phase.
`timescale 1ns/1ns
`include "csp_consts.svh"

module csp_timebase
  import csp_pkg::*;
#(
  parameter int PS_SEL_WIDTH   = 3,
  parameter int POST_SEL_WIDTH = 4
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      sys_rst,
  // Control
  input  wire logic                      sleepReq,
  input  wire logic                      runBit,
  input  wire logic [PS_SEL_WIDTH-1:0]   prescaleSel,
  input  wire logic [POST_SEL_WIDTH-1:0] postscaleSel,
  input  wire logic [7:0]                periodLimit,
  // Counter write
  input  wire logic                      countWrEn,
  input  wire logic [7:0]                countWrData,
  // Time base
  output logic      [9:0]                timeBase,
  output logic      [7:0]                timerCount,
  output logic                           periodMatch,
  output logic                           postscaleEvent
);

  localparam int PS_CNT_WIDTH = (1 << PS_SEL_WIDTH) - 1;

  if (PS_SEL_WIDTH < 1 || PS_SEL_WIDTH > 4) begin : gChkPs
    $error("csp_timebase: PS_SEL_WIDTH must be 1 to 4");
  end
  if (POST_SEL_WIDTH < 1 || POST_SEL_WIDTH > 8) begin : gChkPost
    $error("csp_timebase: POST_SEL_WIDTH must be 1 to 8");
  end

  logic [PS_CNT_WIDTH-1:0]   psCnt_q,   psCnt_d;
  logic [1:0]                phase_q,   phase_d;
  logic [7:0]                count_q,   count_d;
  logic [POST_SEL_WIDTH-1:0] postCnt_q, postCnt_d;
  logic [PS_CNT_WIDTH-1:0]   psLast;
  logic                      phaseTick;
  logic                      stepTick;

  // ============================================================
  // Next state
  always_comb begin
    psLast    = PS_CNT_WIDTH'((1 << prescaleSel) - 1);
    psCnt_d   = psCnt_q;
    phase_d   = phase_q;
    count_d   = count_q;
    postCnt_d = postCnt_q;
    phaseTick = 1'b0;
    stepTick  = 1'b0;
    periodMatch    = 1'b0;
    postscaleEvent = 1'b0;
    if (countWrEn) begin
      count_d = countWrData;
      psCnt_d = '0;
      phase_d = '0;
    end else if (runBit && !sleepReq) begin
      phaseTick = (psCnt_q >= psLast);
      stepTick  = phaseTick && (phase_q == `CSP_PHASE_LAST);
      psCnt_d   = phaseTick ? '0 : psCnt_q + 1'b1;
      if (phaseTick) begin
        phase_d = phase_q + 2'h1;
      end
      if (stepTick) begin
        if (count_q == periodLimit) begin
          count_d     = '0;
          periodMatch = 1'b1;
          // Postscaler paces only the rollover flag
          if (postCnt_q >= postscaleSel) begin
            postCnt_d      = '0;
            postscaleEvent = 1'b1;
          end else begin
            postCnt_d = postCnt_q + 1'b1;
          end
        end else begin
          count_d = count_q + 8'h01;
        end
      end
    end
  end

  // ============================================================
  // Registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      psCnt_q   <= '0;
      phase_q   <= '0;
      count_q   <= `CSP_COUNT_RST;
      postCnt_q <= '0;
    end else begin
      psCnt_q   <= psCnt_d;
      phase_q   <= phase_d;
      count_q   <= count_d;
      postCnt_q <= postCnt_d;
    end
  end

  // Next time base: the pin falls on the very edge where the count reaches the duty
  assign timeBase   = {count_d, phase_d};
  assign timerCount = count_q;

endmodule : csp_timebase

/* rtl/csp_standard_pwm.sv */
// Purpose: Standard 10-bit PWM mode of a capture/compare/PWM unit, driving one pin.
// Assumes: Software follows the setup order and clocks the timer at system clock / 4.
// Notes:   Capture and compare modes are not built; in those modes the output stays low.
`timescale 1ns/1ns
`include "csp_consts.svh"

module csp_standard_pwm
  import csp_pkg::*;
#(
  parameter int PS_SEL_WIDTH   = 3,
  parameter int POST_SEL_WIDTH = 4
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Power state
  input  wire logic       sleepReq,
  // Register writes: one data byte, one strobe per register
  input  wire logic [7:0] wrData,
  input  wire logic       unitControlWr,
  input  wire logic       dutyLowWr,
  input  wire logic       dutyHighWr,
  input  wire logic       periodLimitWr,
  input  wire logic       timerControlWr,
  input  wire logic       timerCountWr,
  input  wire logic       pinDirectionWr,
  input  wire logic       openDrainWr,
  input  wire logic       rolloverFlagClr,
  // Register readback
  output logic      [7:0] unitControlRd,
  output logic      [15:0] dutyValueRd,
  output logic      [7:0] periodLimitRd,
  output logic      [7:0] timerControlRd,
  output logic      [7:0] timerCountRd,
  output logic            pinDirectionRd,
  output logic            openDrainRd,
  output logic            timerRolloverFlag,
  // Status
  output logic      [3:0] resolutionBits,
  output logic            pwmActive,
  // Output pin
  output logic            pwmOutputPin,
  output logic            pwmOutputPinOe
);

  if (PS_SEL_WIDTH < 1 || PS_SEL_WIDTH > 3) begin : gChkPs
    $error("csp_standard_pwm: PS_SEL_WIDTH must be 1 to 3");
  end
  if (POST_SEL_WIDTH < 1 || POST_SEL_WIDTH > 4) begin : gChkPost
    $error("csp_standard_pwm: POST_SEL_WIDTH must be 1 to 4");
  end

  // ============================================================
  // Helpers

  // Extract the 10-bit duty from the two bytes for the chosen alignment
  function automatic logic [9:0] alignDuty(input logic [7:0] hi,
                                           input logic [7:0] lo,
                                           input csp_align_type align);
    logic [9:0] val;
    val = '0;
    if (align == CSP_ALIGN_LEFT) begin
      val = {hi, lo[7:6]};
    end else begin
      val = {hi[1:0], lo};
    end
    return val;
  endfunction : alignDuty

  // Bits needed to number 4 * (limit + 1) steps
  function automatic logic [3:0] stepsLog2(input logic [7:0] limit);
    logic [9:0] steps;
    logic [3:0] bits;
    steps = {limit, 2'h3};
    bits  = 4'h0;
    for (int i = 0; i < 10; i++) begin
      if (steps[i]) begin
        bits = 4'(i + 1);
      end
    end
    return bits;
  endfunction : stepsLog2

  // Decode operating mode from the control byte
  function automatic csp_mode_type decodeMode(input logic [7:0] ctrl);
    csp_mode_type m;
    m = CSP_MODE_OFF;
    if (!ctrl[`CSP_CTRL_EN_BIT]) begin
      m = CSP_MODE_OFF;
    end else if (ctrl[`CSP_CTRL_MODE_MSB -: 2] == `CSP_MODE_PWM_TOP) begin
      m = CSP_MODE_PWM;
    end else begin
      m = CSP_MODE_OTHER;
    end
    return m;
  endfunction : decodeMode

  // ============================================================
  // Software-written registers
  logic [7:0] ctrl_q,       ctrl_d;
  logic [7:0] dutyHigh_q,   dutyHigh_d;
  logic [7:0] dutyLow_q,    dutyLow_d;
  logic [7:0] period_q,     period_d;
  logic [7:0] tctrl_q,      tctrl_d;
  logic       pinDir_q,     pinDir_d;
  logic       openDrain_q,  openDrain_d;

  always_comb begin
    ctrl_d      = ctrl_q;
    dutyHigh_d  = dutyHigh_q;
    dutyLow_d   = dutyLow_q;
    period_d    = period_q;
    tctrl_d     = tctrl_q;
    pinDir_d    = pinDir_q;
    openDrain_d = openDrain_q;
    if (unitControlWr) begin
      ctrl_d = wrData & `CSP_CTRL_WR_MASK;
    end
    // Duty bytes are taken at any time
    if (dutyHighWr) begin
      dutyHigh_d = wrData;
    end
    if (dutyLowWr) begin
      dutyLow_d = wrData;
    end
    if (periodLimitWr) begin
      period_d = wrData;
    end
    if (timerControlWr) begin
      tctrl_d = wrData;
    end
    if (pinDirectionWr) begin
      pinDir_d = wrData[0];
    end
    if (openDrainWr) begin
      openDrain_d = wrData[0];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_q      <= `CSP_CTRL_RST;
      dutyHigh_q  <= `CSP_DUTY_RST;
      dutyLow_q   <= `CSP_DUTY_RST;
      period_q    <= `CSP_PERIOD_RST;
      tctrl_q     <= `CSP_TCTRL_RST;
      pinDir_q    <= `CSP_PIN_DIR_RST;
      openDrain_q <= `CSP_OPEN_DRAIN_RST;
    end else begin
      ctrl_q      <= ctrl_d;
      dutyHigh_q  <= dutyHigh_d;
      dutyLow_q   <= dutyLow_d;
      period_q    <= period_d;
      tctrl_q     <= tctrl_d;
      pinDir_q    <= pinDir_d;
      openDrain_q <= openDrain_d;
    end
  end

  // ============================================================
  // Period timer
  logic [9:0]                timeBase;
  logic [7:0]                timerCount;
  logic                      periodMatch;
  logic                      postscaleEvent;
  logic [PS_SEL_WIDTH-1:0]   prescaleSel;
  logic [POST_SEL_WIDTH-1:0] postscaleSel;

  assign prescaleSel  = tctrl_q[`CSP_TCTRL_PS_LSB +: PS_SEL_WIDTH];
  assign postscaleSel = tctrl_q[`CSP_TCTRL_POST_LSB +: POST_SEL_WIDTH];

  csp_timebase #(
    .PS_SEL_WIDTH   (PS_SEL_WIDTH),
    .POST_SEL_WIDTH (POST_SEL_WIDTH)
  ) uTimebase (
    .clk            (clk),
    .sys_rst        (sys_rst),
    .sleepReq       (sleepReq),
    .runBit         (tctrl_q[`CSP_TCTRL_RUN_BIT]),
    .prescaleSel    (prescaleSel),
    .postscaleSel   (postscaleSel),
    .periodLimit    (period_q),
    .countWrEn      (timerCountWr),
    .countWrData    (wrData),
    .timeBase       (timeBase),
    .timerCount     (timerCount),
    .periodMatch    (periodMatch),
    .postscaleEvent (postscaleEvent)
  );

  // ============================================================
  // Rollover flag: a new event wins over a clear in the same cycle
  logic flag_q, flag_d;

  always_comb begin
    flag_d = flag_q;
    if (rolloverFlagClr) begin
      flag_d = 1'b0;
    end
    if (postscaleEvent) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ============================================================
  // Duty shadow, comparator and output latch
  csp_mode_type  mode;
  csp_align_type align;
  logic [9:0]    dutyNow;
  logic [9:0]    shadow_q, shadow_d;
  logic          out_q,    out_d;

  assign mode    = decodeMode(ctrl_q);
  assign align   = csp_align_type'(ctrl_q[`CSP_CTRL_ALIGN_BIT]);
  assign dutyNow = alignDuty(dutyHigh_q, dutyLow_q, align);

  always_comb begin
    shadow_d = shadow_q;
    out_d    = out_q;
    if (sleepReq) begin
      // Hold everything while asleep
      shadow_d = shadow_q;
      out_d    = out_q;
    end else if (mode != CSP_MODE_PWM) begin
      out_d = 1'b0;
    end else if (periodMatch) begin
      shadow_d = dutyNow;
      out_d    = (dutyNow != 10'h000);
    end else if (timeBase == shadow_q) begin
      // Duty past the period never matches, so the pin stays as it is
      out_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shadow_q <= '0;
      out_q    <= 1'b0;
    end else begin
      shadow_q <= shadow_d;
      out_q    <= out_d;
    end
  end

  // ============================================================
  // Pin and readback
  // Open drain releases the pin while the waveform is high
  assign pwmOutputPin   = out_q;
  assign pwmOutputPinOe = !pinDir_q && (!openDrain_q || !out_q);

  assign unitControlRd     = {ctrl_q[7:6], out_q, ctrl_q[4:0]};
  assign dutyValueRd       = {dutyHigh_q, dutyLow_q};
  assign periodLimitRd     = period_q;
  assign timerControlRd    = tctrl_q;
  assign timerCountRd      = timerCount;
  assign pinDirectionRd    = pinDir_q;
  assign openDrainRd       = openDrain_q;
  assign timerRolloverFlag = flag_q;
  assign resolutionBits    = stepsLog2(period_q);
  assign pwmActive         = (mode == CSP_MODE_PWM);

endmodule : csp_standard_pwm

/* tb/csp_pwm_chk.sv */
// Purpose: Port-level checks of the standard PWM unit.
// Assumes: One clock domain, synchronous active-high reset.
// Notes:   Attached by bind below.
`timescale 1ns/1ns
`include "csp_consts.svh"

module csp_pwm_chk
  import csp_pkg::*;
(
  // Clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // Stimulus seen
  input wire logic       sleepReq,
  input wire logic [7:0] wrData,
  input wire logic       unitControlWr,
  input wire logic       timerCountWr,
  input wire logic       rolloverFlagClr,
  // Results seen
  input wire logic [7:0] unitControlRd,
  input wire logic [7:0] periodLimitRd,
  input wire logic [7:0] timerCountRd,
  input wire logic       pinDirectionRd,
  input wire logic       openDrainRd,
  input wire logic       timerRolloverFlag,
  input wire logic [3:0] resolutionBits,
  input wire logic       pwmActive,
  input wire logic       pwmOutputPin,
  input wire logic       pwmOutputPinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence offWrS;
    unitControlWr && !wrData[`CSP_CTRL_EN_BIT];
  endsequence
  sequence stepS;
    timerCountRd != $past(timerCountRd) && !$past(timerCountWr);
  endsequence

  oe_drive_a: assert property (
    pwmOutputPinOe == (!pinDirectionRd && (!openDrainRd || !pwmOutputPin))
  ) else $error("pin enable wrong");
  reset_pin_a: assert property (@(posedge clk) disable iff (1'b0)
    sys_rst |=> !pwmOutputPinOe && pinDirectionRd && !pwmOutputPin
  ) else $error("reset state wrong");
  sleep_freeze_a: assert property (
    sleepReq && $past(sleepReq) && !$past(timerCountWr) && !$past(unitControlWr)
    |-> $stable(timerCountRd) && $stable(pwmOutputPin)) else $error("sleep not frozen");
  disable_low_a: assert property (
    offWrS |-> ##2 !pwmOutputPin
  ) else $error("output high while off");
  res_bits_a: assert property (
    resolutionBits == 4'($clog2(4 * (int'(periodLimitRd) + 1)))
  ) else $error("resolution wrong");
  active_flag_a: assert property (
    pwmActive == (unitControlRd[`CSP_CTRL_EN_BIT] && unitControlRd[3:2] == 2'b11)
  ) else $error("active flag wrong");
  count_wrap_a: assert property (
    stepS and ($past(timerCountRd) == $past(periodLimitRd)) |-> timerCountRd == 8'h00
  ) else $error("counter not cleared at limit");
  step_one_a: assert property (
    stepS and ($past(timerCountRd) != $past(periodLimitRd))
    |-> timerCountRd == 8'($past(timerCountRd) + 8'h01)) else $error("counter skipped");
  rise_match_a: assert property (
    $rose(pwmOutputPin) |-> timerCountRd == 8'h00
  ) else $error("output set off match");
  flag_hold_a: assert property (
    timerRolloverFlag && !rolloverFlagClr |=> timerRolloverFlag
  ) else $error("flag lost");
endmodule : csp_pwm_chk

bind csp_standard_pwm csp_pwm_chk u_chk (.clk, .sys_rst, .sleepReq, .wrData, .unitControlWr,
  .timerCountWr, .rolloverFlagClr, .unitControlRd, .periodLimitRd, .timerCountRd,
  .pinDirectionRd, .openDrainRd, .timerRolloverFlag, .resolutionBits, .pwmActive,
  .pwmOutputPin, .pwmOutputPinOe);

/* tb/testbench.sv */
// Purpose: Self-checking bench of the standard PWM unit.
// Assumes: Inputs driven at rising edges; notes compared at falling edges.
// Notes:   Pulse and period lengths are measured on the output pin.
`timescale 1ns/1ns
`include "csp_consts.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t kind %0d got %0h exp %0h", $time, n.kind, g, e); end end

module testbench;
  import csp_pkg::*;
  typedef struct { int kind; logic [31:0] exp; } csp_note_type;
  logic        clk = 1'b0, sys_rst = 1'b1, sleepReq = 1'b0, prevPin = 1'b0;
  logic [7:0]  wrData = 8'h00;
  logic [8:0]  stb = 9'h000;
  logic [7:0]  unitControlRd, periodLimitRd, timerControlRd, timerCountRd;
  logic [15:0] dutyValueRd, hiCnt = 0, hiLen = 0, since = 0, perLen = 0, winCnt = 0;
  logic        pinDirectionRd, openDrainRd, timerRolloverFlag, pwmActive;
  logic        pwmOutputPin, pwmOutputPinOe;
  logic [3:0]  resolutionBits;
  logic [31:0] obs;
  int          err_total = 0, cmp_count = 0, cyc = 0, seed = 32'h9217, curP, curHi;
  csp_note_type q[$];
  csp_note_type n;

  always #5 clk = ~clk;

  csp_standard_pwm DUT (.clk, .sys_rst, .sleepReq, .wrData, .unitControlWr(stb[0]),
    .dutyLowWr(stb[1]), .dutyHighWr(stb[2]), .periodLimitWr(stb[3]), .timerControlWr(stb[4]),
    .timerCountWr(stb[5]), .pinDirectionWr(stb[6]), .openDrainWr(stb[7]),
    .rolloverFlagClr(stb[8]), .unitControlRd, .dutyValueRd, .periodLimitRd, .timerControlRd,
    .timerCountRd, .pinDirectionRd, .openDrainRd, .timerRolloverFlag, .resolutionBits,
    .pwmActive, .pwmOutputPin, .pwmOutputPinOe);

  // ============================================================
  // Pin measurement and note checking
  always @(posedge clk) begin
    prevPin <= pwmOutputPin;
    if (pwmOutputPin === 1'b1) winCnt <= winCnt + 1;
    if (pwmOutputPin === 1'b1 && prevPin !== 1'b1) begin
      perLen <= since;
      since <= 1;
      hiCnt <= 1;
    end else begin
      since <= since + 1;
      if (pwmOutputPin === 1'b1) hiCnt <= hiCnt + 1;
      if (pwmOutputPin !== 1'b1 && prevPin === 1'b1) hiLen <= hiCnt;
    end
  end

  initial forever begin
    @(negedge clk);
    if (q.size() > 0) begin
      n = q.pop_front();
      case (n.kind)
        0: obs = 32'(hiLen);
        1: obs = 32'(perLen);
        2: obs = 32'(winCnt);
        3: obs = {unitControlRd, periodLimitRd, timerControlRd, timerCountRd};
        default: obs = {dutyValueRd, pinDirectionRd, openDrainRd, timerRolloverFlag,
                        pwmActive, resolutionBits, 7'h00, pwmOutputPinOe};
      endcase
      `CHK(obs, n.exp)
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end

  // ============================================================
  // Tasks
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  task automatic note(input int k, input logic [31:0] e);
    q.push_back('{k, e});
  endtask : note

  task automatic wr(input int w, input logic [7:0] d);
    @(posedge clk);
    wrData <= d;
    stb <= 9'(1 << w);
    @(posedge clk);
    stb <= 9'h000;
  endtask : wr

  task automatic window(input int len, input int expHi);
    int base;
    @(posedge clk);
    base = winCnt;
    repeat (len - 1) @(posedge clk);
    note(2, 32'(base + expHi));
  endtask : window

  task automatic run_pwm(input logic [7:0] lim, input logic [2:0] sel, input logic [3:0] post,
                         input logic [9:0] duty, input logic left);
    logic [7:0] dh, dl;
    curP = (lim + 1) * 4 * (1 << sel);
    curHi = duty * (1 << sel);
    if (curHi > curP) curHi = curP;
    dh = left ? duty[9:2] : {6'h00, duty[9:8]};
    dl = left ? {duty[1:0], 6'h00} : duty[7:0];
    wr(6, 8'h01);
    wr(4, 8'h00);
    wr(5, 8'h00);
    wr(3, lim);
    wr(0, {1'b1, 2'b00, left, 4'hc});
    wr(2, dh);
    wr(1, dl);
    wr(8, 8'h00);
    wr(4, {1'b1, sel, post});
    for (int i = 0; i < 20000 && timerRolloverFlag !== 1'b1; i++) @(posedge clk);
    wr(6, 8'h00);
    repeat (3 * curP) @(posedge clk);
    if (curHi > 0 && curHi < curP) begin
      note(0, 32'(curHi));
      note(1, 32'(curP));
    end
    window(2 * curP, 2 * curHi);
    note(4, {dh, dl, 4'b0011, 4'($clog2(4 * (lim + 1))), 8'h01});
  endtask : run_pwm

  task automatic chk_reset();
    note(3, {8'h00, 8'hff, 8'h00, 8'h00});
    note(4, {16'h0000, 4'b1000, 4'ha, 8'h00});
  endtask : chk_reset

  // ============================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_reset();
    $display("test reset done");
    run_pwm(8'h00, 3'h0, 4'h0, 10'd2, 1'b0);
    run_pwm(8'h03, 3'h0, 4'h3, 10'd5, 1'b0);
    run_pwm(8'h03, 3'h1, 4'h0, 10'd5, 1'b1);
    run_pwm(8'h7f, 3'h0, 4'h0, 10'd300, 1'b0);
    run_pwm(8'h00, 3'h0, 4'h0, 10'd10, 1'b0);
    run_pwm(8'h03, 3'h0, 4'h0, 10'd0, 1'b0);
    run_pwm(8'h03, 3'h0, 4'h1, 10'(1 + $unsigned($random(seed)) % 15), 1'b1);
    $display("test waveform done");
    // New duty written while the timer runs, left aligned value 7
    wr(2, 8'h01);
    wr(1, 8'hc0);
    curHi = 7;
    repeat (3 * curP) @(posedge clk);
    note(0, 32'd7);
    window(2 * curP, 14);
    $display("test duty update done");
    wr(7, 8'h01);
    @(posedge clk);
    sleepReq <= 1'b1;
    repeat (30) @(posedge clk);
    sleepReq <= 1'b0;
    wr(7, 8'h00);
    window(2 * curP, 2 * curHi);
    $display("test sleep done");
    wr(0, 8'h0c);
    window(2 * curP, 0);
    $display("test disable done");
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk_reset();
    $display("test second reset done");
    repeat (3) @(posedge clk);
    close_out();
  end
endmodule : testbench
